/* File: design/ooscc_osc.sv */
`timescale 1ns/1ns
module ooscc_osc (
	input wire logic clk,
	input wire logic rst_n,
	ooscc_osc_if.osc link
);
	import ooscc_pkg::*;

	logic [CNT_W-1:0] phase, next_phase, period, next_period;
	logic [CNT_W-1:0] duty, next_duty;
	logic startQ, dutyQ;

	always_comb begin
		next_period = period;
		next_duty = duty;
		next_phase = phase + 1'b1;
		if (phase == period - 1'b1) begin
			next_phase = '0;
			// New rate takes effect only at a period boundary
			if (link.hfVariant) begin
				next_period = PERIOD_HI;
				next_duty = DUTY_HI;
			end else if (link.skipping) begin
				next_period = PERIOD_FAST;
				next_duty = DUTY_FAST;
			end else begin
				next_period = PERIOD_LO;
				next_duty = DUTY_LO;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= '0;
			period <= PERIOD_LO;
			duty <= DUTY_LO;
			startQ <= 1'b0;
			dutyQ <= 1'b0;
		end else begin
			phase <= next_phase;
			period <= next_period;
			duty <= next_duty;
			startQ <= (next_phase == '0);
			dutyQ <= (next_phase < next_duty);
		end
	end

	assign link.cycleStart = startQ;
	assign link.dutyWindow = dutyQ;

	// Helper counters for the checks below
	logic [CNT_W-1:0] sinceStart, hiCnt, seenPeriod, seenDuty;
	logic seen;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sinceStart <= '0;
			hiCnt <= '0;
			seenPeriod <= '0;
			seenDuty <= '0;
			seen <= 1'b0;
		end else begin
			hiCnt <= dutyQ ? hiCnt + 1'b1 : '0;
			if (startQ) begin
				sinceStart <= '0;
				seenPeriod <= period;
				seenDuty <= duty;
				seen <= 1'b1;
			end else begin
				sinceStart <= sinceStart + 1'b1;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_period_len: assert property (
		startQ && seen |-> sinceStart == seenPeriod - 1'b1)
		else $error("oscillator period length wrong");
	chk_duty_width: assert property (
		$fell(dutyQ) && seen |-> hiCnt == seenDuty)
		else $error("max duty window width wrong");
	chk_fast_rate: assert property (
		startQ && !$past(link.hfVariant) && $past(link.skipping)
		|-> period == PERIOD_FAST)
		else $error("skip rate not doubled");
	cov_fast_period: cover property (startQ && period == PERIOD_FAST);

endmodule // ooscc_osc

/* File: design/ooscc_osc_if.sv */
`timescale 1ns/1ns
interface ooscc_osc_if;
	logic cycleStart;
	logic dutyWindow;
	logic hfVariant;
	logic skipping;
	modport osc (output cycleStart, output dutyWindow,
		input hfVariant, input skipping);
	modport ctl (input cycleStart, input dutyWindow,
		output hfVariant, output skipping);
endinterface

/* File: design/ooscc_pkg.sv */
package ooscc_pkg;

	// Clock and oscillator
	localparam int CLK_HZ = 100_000_000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int OSC_LO_HZ = 44_000;
	localparam int OSC_HI_HZ = 130_000;
	localparam int DUTY_PCT = 67;
	localparam int CNT_W = 12;
	localparam int PERIOD_LO_INT = CLK_HZ / OSC_LO_HZ;
	localparam int PERIOD_HI_INT = CLK_HZ / OSC_HI_HZ;
	localparam logic [CNT_W-1:0] PERIOD_LO = CNT_W'(PERIOD_LO_INT);
	localparam logic [CNT_W-1:0] PERIOD_FAST = CNT_W'(PERIOD_LO_INT / 2);
	localparam logic [CNT_W-1:0] PERIOD_HI = CNT_W'(PERIOD_HI_INT);
	localparam logic [CNT_W-1:0] DUTY_LO =
		CNT_W'(PERIOD_LO_INT * DUTY_PCT / 100);
	localparam logic [CNT_W-1:0] DUTY_FAST =
		CNT_W'((PERIOD_LO_INT / 2) * DUTY_PCT / 100);
	localparam logic [CNT_W-1:0] DUTY_HI =
		CNT_W'(PERIOD_HI_INT * DUTY_PCT / 100);

	// Blanking after turn-on, least time so rounded up
	localparam int BLANK_NS = 200;
	localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BLANK_W = 8;

	// Pin positions in the synchroniser vector
	localparam int PIN_N = 6;
	localparam int PIN_EN = 0;
	localparam int PIN_SUP_LOW = 1;
	localparam int PIN_SUP_HIGH = 2;
	localparam int PIN_TEMP_HOT = 3;
	localparam int PIN_TEMP_COOL = 4;
	localparam int PIN_CUR_LIM = 5;

	// Register map
	localparam int REG_AW = 8;
	localparam logic [REG_AW-1:0] REG_CTRL = 8'h00;
	localparam logic [REG_AW-1:0] REG_STATUS = 8'h04;
	localparam logic [REG_AW-1:0] REG_SWITCHES = 8'h08;
	localparam logic [REG_AW-1:0] REG_SKIPS = 8'h0C;
	localparam int CTRL_HF_BIT = 0;
	localparam int CTRL_OFF_BIT = 1;
	localparam logic CTRL_HF_RST = 1'b0;
	localparam logic CTRL_OFF_RST = 1'b0;
	localparam int ST_GATE = 0;
	localparam int ST_UV = 1;
	localparam int ST_OT = 2;
	localparam int ST_SKIP = 3;
	localparam int ST_TRIP = 4;
	localparam int ST_EN = 5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {CYC_OFF, CYC_BLANK, CYC_CONDUCT} ooscc_cyc_e;

endpackage

/* File: design/ooscc_top.sv */
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
// Notes on behaviour
// - Oscillator period is 44 kHz, or 130 kHz for the fast variant.
// - Max duty window is high for about 67% of each period.
// - A cycle-start pulse marks the beginning of each switching cycle.
// - Skipping doubles the slow oscillator rate; fast variant stays at 130 kHz.
// - Feedback enable is sampled once per cycle at cycle start.
// - Enable high switches this cycle; low keeps switch off, cycle skipped.
// - Enable changes after the sample are ignored until next cycle.
// - Supply below 5.1 V locks out; release only at 5.8 V.
// - Over 135 C locks out until temperature falls by 70 C.
// - Current over limit ends the pulse for the rest of cycle.
// - Current comparator is masked for a blanking time after turn-on.
// - On-time never extends more than one clock past the end of the max duty window.
// - A started cycle always completes despite mid-cycle enable changes.
module ooscc_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ooscc_pkg::REG_AW-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ooscc_pkg::REG_AW-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic feedbackEnable,
	input wire logic supplyBelowLow,
	input wire logic supplyAboveHigh,
	input wire logic tempAboveTrip,
	input wire logic tempCooled,
	input wire logic currentLimit,
	output logic gateDrive
);
	import ooscc_pkg::*;

	ooscc_osc_if cyc ();

	ooscc_osc u_osc (
		.clk(clk),
		.rst_n(rst_n),
		.link(cyc.osc)
	);

	// Pin synchronisers: a change is taken once stages two and three agree
	logic [PIN_N-1:0] pinRaw, pinFilt;
	assign pinRaw[PIN_EN] = feedbackEnable;
	assign pinRaw[PIN_SUP_LOW] = supplyBelowLow;
	assign pinRaw[PIN_SUP_HIGH] = supplyAboveHigh;
	assign pinRaw[PIN_TEMP_HOT] = tempAboveTrip;
	assign pinRaw[PIN_TEMP_COOL] = tempCooled;
	assign pinRaw[PIN_CUR_LIM] = currentLimit;

	generate
		for (genvar i = 0; i < PIN_N; i++) begin : g_sync
			logic st1, st2, st3, filt;
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					st1 <= 1'b0;
					st2 <= 1'b0;
					st3 <= 1'b0;
					filt <= 1'b0;
				end else begin
					st1 <= pinRaw[i];
					st2 <= st1;
					st3 <= st2;
					if (st2 == st3) begin
						filt <= st3;
					end
				end
			end
			assign pinFilt[i] = filt;
		end
	endgenerate

	logic enFilt, supLow, supHigh, tempHot, tempCool, curFilt;
	assign enFilt = pinFilt[PIN_EN];
	assign supLow = pinFilt[PIN_SUP_LOW];
	assign supHigh = pinFilt[PIN_SUP_HIGH];
	assign tempHot = pinFilt[PIN_TEMP_HOT];
	assign tempCool = pinFilt[PIN_TEMP_COOL];
	assign curFilt = pinFilt[PIN_CUR_LIM];

	// Lockouts
	logic uvLock, next_uvLock, otLock, next_otLock;
	logic hfVariant, swDisable, anyLock;

	always_comb begin
		next_uvLock = uvLock;
		next_otLock = otLock;
		// Falling below the low threshold wins over a stale high reading
		if (supLow) begin
			next_uvLock = 1'b1;
		end else if (supHigh) begin
			next_uvLock = 1'b0;
		end
		if (tempHot) begin
			next_otLock = 1'b1;
		end else if (tempCool) begin
			next_otLock = 1'b0;
		end
	end

	// Locked at reset: the supply has not yet been seen up at 5.8 V
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			uvLock <= 1'b1;
			otLock <= 1'b0;
		end else begin
			uvLock <= next_uvLock;
			otLock <= next_otLock;
		end
	end

	assign anyLock = uvLock | otLock | swDisable;

	// Switching cycle
	ooscc_cyc_e state, next_state;
	logic [BLANK_W-1:0] blankCnt, next_blankCnt;
	logic curTrip, next_curTrip, skipping, next_skipping;
	logic enSample, next_enSample, gate, next_gate;
	logic [31:0] switchCnt, next_switchCnt, skipCnt, next_skipCnt;

	always_comb begin
		next_state = state;
		next_blankCnt = blankCnt;
		next_curTrip = curTrip;
		next_skipping = skipping;
		next_enSample = enSample;
		next_switchCnt = switchCnt;
		next_skipCnt = skipCnt;
		if (cyc.cycleStart) begin
			next_enSample = enFilt;
			next_curTrip = 1'b0;
			next_blankCnt = '0;
			if (enFilt && !anyLock) begin
				next_state = CYC_BLANK;
				next_skipping = 1'b0;
				next_switchCnt = switchCnt + 1'b1;
			end else begin
				next_state = CYC_OFF;
				next_skipping = 1'b1;
				next_skipCnt = skipCnt + 1'b1;
			end
		end else begin
			// Enable is not looked at here, so the cycle runs out
			case (state)
				CYC_BLANK: begin
					if (anyLock || !cyc.dutyWindow) begin
						next_state = CYC_OFF;
					end else if (blankCnt == BLANK_W'(BLANK_CYC - 1)) begin
						next_state = CYC_CONDUCT;
					end else begin
						next_blankCnt = blankCnt + 1'b1;
					end
				end
				CYC_CONDUCT: begin
					if (curFilt) begin
						next_curTrip = 1'b1;
						next_state = CYC_OFF;
					end else if (anyLock || !cyc.dutyWindow) begin
						next_state = CYC_OFF;
					end
				end
				default: begin
					next_state = CYC_OFF;
				end
			endcase
		end
		next_gate = (next_state == CYC_BLANK || next_state == CYC_CONDUCT)
			&& cyc.dutyWindow && !next_curTrip && !anyLock;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= CYC_OFF;
			blankCnt <= '0;
			curTrip <= 1'b0;
			skipping <= 1'b0;
			enSample <= 1'b0;
			gate <= 1'b0;
			switchCnt <= '0;
			skipCnt <= '0;
		end else begin
			state <= next_state;
			blankCnt <= next_blankCnt;
			curTrip <= next_curTrip;
			skipping <= next_skipping;
			enSample <= next_enSample;
			gate <= next_gate;
			switchCnt <= next_switchCnt;
			skipCnt <= next_skipCnt;
		end
	end

	assign gateDrive = gate;
	assign cyc.skipping = skipping;
	assign cyc.hfVariant = hfVariant;

	// AXI4-Lite slave, one write and one read in flight
	logic awHeld, next_awHeld, wHeld, next_wHeld;
	logic [REG_AW-1:0] awAddr, next_awAddr;
	logic [31:0] wData, next_wData;
	logic [3:0] wStrb, next_wStrb;
	logic bValid, next_bValid, rValid, next_rValid;
	logic [1:0] bResp, next_bResp, rResp, next_rResp;
	logic [31:0] rData, next_rData, statusWord;
	logic next_hfVariant, next_swDisable;

	assign s_axi_awready = !awHeld && !bValid;
	assign s_axi_wready = !wHeld && !bValid;
	assign s_axi_arready = !rValid;

	always_comb begin
		statusWord = '0;
		statusWord[ST_GATE] = gate;
		statusWord[ST_UV] = uvLock;
		statusWord[ST_OT] = otLock;
		statusWord[ST_SKIP] = skipping;
		statusWord[ST_TRIP] = curTrip;
		statusWord[ST_EN] = enSample;
	end

	always_comb begin
		next_awHeld = awHeld;
		next_wHeld = wHeld;
		next_awAddr = awAddr;
		next_wData = wData;
		next_wStrb = wStrb;
		next_bValid = bValid;
		next_bResp = bResp;
		next_rValid = rValid;
		next_rResp = rResp;
		next_rData = rData;
		next_hfVariant = hfVariant;
		next_swDisable = swDisable;
		if (s_axi_awvalid && s_axi_awready) begin
			next_awHeld = 1'b1;
			next_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_wHeld = 1'b1;
			next_wData = s_axi_wdata;
			next_wStrb = s_axi_wstrb;
		end
		if (awHeld && wHeld) begin
			next_awHeld = 1'b0;
			next_wHeld = 1'b0;
			next_bValid = 1'b1;
			next_bResp = RESP_OKAY;
			case (awAddr)
				REG_CTRL: begin
					if (wStrb[0]) begin
						next_hfVariant = wData[CTRL_HF_BIT];
						next_swDisable = wData[CTRL_OFF_BIT];
					end
				end
				REG_STATUS, REG_SWITCHES, REG_SKIPS: begin
					next_bResp = RESP_OKAY;
				end
				default: begin
					next_bResp = RESP_SLVERR;
				end
			endcase
		end
		if (bValid && s_axi_bready) begin
			next_bValid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rValid = 1'b1;
			next_rResp = RESP_OKAY;
			case (s_axi_araddr)
				REG_CTRL: begin
					next_rData = '0;
					next_rData[CTRL_HF_BIT] = hfVariant;
					next_rData[CTRL_OFF_BIT] = swDisable;
				end
				REG_STATUS: next_rData = statusWord;
				REG_SWITCHES: next_rData = switchCnt;
				REG_SKIPS: next_rData = skipCnt;
				default: begin
					next_rData = '0;
					next_rResp = RESP_SLVERR;
				end
			endcase
		end else if (rValid && s_axi_rready) begin
			next_rValid = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= '0;
			wData <= '0;
			wStrb <= '0;
			bValid <= 1'b0;
			bResp <= RESP_OKAY;
			rValid <= 1'b0;
			rResp <= RESP_OKAY;
			rData <= '0;
			hfVariant <= CTRL_HF_RST;
			swDisable <= CTRL_OFF_RST;
		end else begin
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			awAddr <= next_awAddr;
			wData <= next_wData;
			wStrb <= next_wStrb;
			bValid <= next_bValid;
			bResp <= next_bResp;
			rValid <= next_rValid;
			rResp <= next_rResp;
			rData <= next_rData;
			hfVariant <= next_hfVariant;
			swDisable <= next_swDisable;
		end
	end

	assign s_axi_bvalid = bValid;
	assign s_axi_bresp = bResp;
	assign s_axi_rvalid = rValid;
	assign s_axi_rresp = rResp;
	assign s_axi_rdata = rData;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_gate_window_lock: assert property (
		gate |-> $past(cyc.dutyWindow) && !$past(anyLock))
		else $error("gate on outside window or under lockout");
	chk_enable_once: assert property (
		$changed(enSample) |-> $past(cyc.cycleStart))
		else $error("enable sampled away from cycle start");
	chk_skip_dark: assert property (
		cyc.cycleStart && !enFilt |=> !gate [*3])
		else $error("gate on in skipped cycle");
	chk_switch_on: assert property (
		cyc.cycleStart && enFilt && !anyLock |=> gate)
		else $error("enabled cycle did not turn on");
	chk_ignore_enable: assert property (
		state == CYC_BLANK && !cyc.cycleStart && !anyLock
		&& cyc.dutyWindow |=> state != CYC_OFF)
		else $error("started cycle abandoned");
	chk_curlim_end: assert property (
		state == CYC_CONDUCT && curFilt && !cyc.cycleStart
		|=> !gate [*4])
		else $error("current limit did not end pulse");
	chk_blank_mask: assert property (
		state == CYC_BLANK && !cyc.cycleStart |=> !curTrip)
		else $error("current limit acted during blanking");
	chk_blank_len: assert property (
		$rose(state == CYC_CONDUCT) |-> $past(blankCnt) == BLANK_CYC - 1)
		else $error("blanking length wrong");
	chk_window_end: assert property (
		$fell(cyc.dutyWindow) |=> !gate)
		else $error("gate beyond max duty window");
	chk_uv_hold: assert property (
		uvLock && !supHigh |=> uvLock)
		else $error("undervoltage lock released early");
	chk_uv_trip: assert property (
		supLow |=> uvLock ##1 !gate)
		else $error("undervoltage did not lock out");
	chk_ot_hold: assert property (
		otLock && !tempCool |=> otLock)
		else $error("thermal lock released early");

	cov_switch_cycle: cover property (cyc.cycleStart && enFilt && !anyLock);
	cov_skip_cycle: cover property (cyc.cycleStart && !enFilt);
	cov_cur_trip: cover property ($rose(curTrip));
	cov_uv_release: cover property ($fell(uvLock));

endmodule // ooscc_top

/* File: test/ooscc_opto_model.sv */
`timescale 1ns/1ns
module ooscc_opto_model #(
	parameter int LAG = 3
) (
	input wire logic clk,
	input wire logic demand,
	output logic feedbackEnable
);
	// Lag stands for the secondary comparator and optocoupler delay
	logic [LAG-1:0] pipe = '0;

	// Transistor pulls the pin low to stop, releases it to run
	always @(posedge clk) begin
		pipe <= {pipe[LAG-2:0], demand};
	end
	assign feedbackEnable = pipe[LAG-1];
endmodule // ooscc_opto_model

/* File: test/tb.sv */
`timescale 1ns/1ns
module tb;
	import ooscc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [REG_AW-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic demand, feedbackEnable, supplyBelowLow, supplyAboveHigh;
	logic tempAboveTrip, tempCooled, currentLimit, gateDrive;
	int n_mismatch = 0;
	int n_tests = 0;
	int cyc = 0;
	int riseAt = 0;
	int nRise = 0;
	int lastPer = 0;
	int lastHi = 0;
	logic gPrev = 1'b0;

	always #5 clk = ~clk;

	ooscc_top i_dut (
		.clk(clk), .rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .feedbackEnable(feedbackEnable),
		.supplyBelowLow(supplyBelowLow),
		.supplyAboveHigh(supplyAboveHigh),
		.tempAboveTrip(tempAboveTrip), .tempCooled(tempCooled),
		.currentLimit(currentLimit), .gateDrive(gateDrive)
	);

	ooscc_opto_model #(.LAG(3)) i_opto (
		.clk(clk), .demand(demand), .feedbackEnable(feedbackEnable)
	);

	// Gate edges timed on the falling clock, where outputs are settled
	always @(negedge clk) begin
		cyc++;
		if (gateDrive === 1'b1 && gPrev !== 1'b1) begin
			nRise++;
			lastPer = cyc - riseAt;
			riseAt = cyc;
		end
		if (gateDrive !== 1'b1 && gPrev === 1'b1)
			lastHi = cyc - riseAt;
		gPrev = gateDrive;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic hung;
		chk(1'b0, 1'b1);
		tally_and_finish;
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wait_rise(input int bound);
		int goal;
		int n;
		goal = nRise + 1;
		n = 0;
		while (nRise < goal && n < bound) begin
			@(negedge clk);
			n++;
		end
		if (nRise < goal)
			hung;
		@(posedge clk);
	endtask

	// Readies looked at on the falling edge: inputs only move on rising
	task automatic axi_wr(input logic [REG_AW-1:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		logic ta, tw, done;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		done = 1'b0;
		while (!done && n < 50) begin
			@(negedge clk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			done = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			n++;
		end
		s_axi_bready <= 1'b0;
		if (!done)
			hung;
	endtask

	task automatic axi_rd(input logic [REG_AW-1:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		logic ta, done;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		done = 1'b0;
		while (!done && n < 50) begin
			@(negedge clk);
			ta = s_axi_arvalid & s_axi_arready;
			done = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk);
			if (ta)
				s_axi_arvalid <= 1'b0;
			n++;
		end
		s_axi_rready <= 1'b0;
		if (!done)
			hung;
	endtask

	task automatic s_regs;
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(REG_CTRL, d, r);
		chk(d, 32'h0);
		axi_rd(REG_STATUS, d, r);
		chk(d[ST_UV], 1'b1);
		chk(d[ST_GATE], 1'b0);
		axi_wr(REG_STATUS, 32'h0, r);
		chk(r, RESP_OKAY);
		axi_rd(REG_STATUS, d, r);
		chk(d[ST_UV], 1'b1);
		axi_rd(8'h10, d, r);
		chk(r, RESP_SLVERR);
		axi_wr(8'h10, 32'h1, r);
		chk(r, RESP_SLVERR);
	endtask

	task automatic s_run;
		supplyAboveHigh <= 1'b1;
		demand <= 1'b1;
		wait_rise(5000);
		wait_rise(3000);
		chk(lastPer, PERIOD_LO);
		wait_clk(1600);
		chk(lastHi >= DUTY_LO - 6 && lastHi <= DUTY_LO, 1'b1);
	endtask

	task automatic s_climit;
		currentLimit <= 1'b1;
		wait_rise(3000);
		wait_clk(100);
		chk(lastHi >= BLANK_CYC && lastHi <= BLANK_CYC + 6, 1'b1);
		wait_clk(600);
		chk(gateDrive, 1'b0);
		// Limit released while the window is still open
		currentLimit <= 1'b0;
		wait_rise(3000);
		chk(lastPer, PERIOD_LO);
	endtask

	task automatic s_mid;
		int n0;
		wait_rise(3000);
		demand <= 1'b0;
		wait_clk(1600);
		chk(lastHi >= DUTY_LO - 6 && lastHi <= DUTY_LO, 1'b1);
		n0 = nRise;
		wait_clk(2 * PERIOD_LO);
		chk(nRise, n0);
	endtask

	task automatic s_skip(input logic [31:0] per);
		logic [31:0] a, b;
		logic [1:0] r;
		axi_rd(REG_SKIPS, a, r);
		wait_clk(10 * per);
		axi_rd(REG_SKIPS, b, r);
		chk(b - a >= 9 && b - a <= 11, 1'b1);
		chk(gateDrive, 1'b0);
	endtask

	task automatic s_hf;
		logic [31:0] d;
		logic [1:0] r;
		axi_wr(REG_CTRL, 32'h1, r);
		axi_rd(REG_CTRL, d, r);
		chk(d, 32'h1);
		wait_clk(PERIOD_LO);
		s_skip(PERIOD_HI);
		demand <= 1'b1;
		wait_rise(3000);
		wait_rise(2000);
		chk(lastPer, PERIOD_HI);
		wait_clk(600);
		chk(lastHi >= DUTY_HI - 6 && lastHi <= DUTY_HI, 1'b1);
		axi_wr(REG_CTRL, 32'h0, r);
	endtask

	task automatic s_lock(input logic thermal);
		int n0;
		logic [31:0] d;
		logic [1:0] r;
		wait_rise(3000);
		if (thermal)
			tempAboveTrip <= 1'b1;
		else
			supplyBelowLow <= 1'b1;
		supplyAboveHigh <= thermal;
		wait_clk(10);
		chk(gateDrive, 1'b0);
		// Back in the hysteresis band: lock must hold
		tempAboveTrip <= 1'b0;
		supplyBelowLow <= 1'b0;
		n0 = nRise;
		wait_clk(2 * PERIOD_LO + 100);
		chk(nRise, n0);
		axi_rd(REG_STATUS, d, r);
		chk(d[thermal ? ST_OT : ST_UV], 1'b1);
		tempCooled <= thermal;
		supplyAboveHigh <= 1'b1;
		wait_rise(3 * PERIOD_LO);
		tempCooled <= 1'b0;
	endtask

	// Software force-off acts as a lockout; switched cycles are counted
	task automatic s_force;
		int n0;
		logic [31:0] a, b, d;
		logic [1:0] r;
		axi_rd(REG_SWITCHES, a, r);
		wait_rise(3000);
		axi_rd(REG_SWITCHES, b, r);
		chk(b - a, 32'h1);
		axi_wr(REG_CTRL, 32'h2, r);
		axi_rd(REG_CTRL, d, r);
		chk(d, 32'h2);
		n0 = nRise;
		wait_clk(2 * PERIOD_LO);
		chk(nRise, n0);
		chk(gateDrive, 1'b0);
		axi_rd(REG_STATUS, d, r);
		chk(d[ST_SKIP], 1'b1);
		axi_wr(REG_CTRL, 32'h0, r);
	endtask

	initial begin
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_wdata = '0;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		demand = 1'b0;
		supplyBelowLow = 1'b0;
		supplyAboveHigh = 1'b0;
		tempAboveTrip = 1'b0;
		tempCooled = 1'b0;
		currentLimit = 1'b0;
		wait_clk(16);
		rst_n <= 1'b1;
		s_regs;
		s_run;
		s_climit;
		s_mid;
		s_skip(PERIOD_FAST);
		s_hf;
		s_lock(1'b0);
		s_lock(1'b1);
		s_force;
		tally_and_finish;
	end
endmodule // tb
